//--- rtl/asl_pkg.sv
// Package of operation codes, operand forms and cycle counts for the subtract/logic/compare datapath.
package asl_pkg;
    typedef enum logic [2:0] {
        ASL_OP_MINUS,
        ASL_OP_MINUS_WITH_BORROW,
        ASL_OP_AND,
        ASL_OP_OR,
        ASL_OP_XOR,
        ASL_OP_COMPARE
    } asl_op_e;

    typedef enum logic [2:0] {
        ASL_FORM_ACC_IMM,
        ASL_FORM_SHORT_IMM,
        ASL_FORM_ACC_REG,
        ASL_FORM_REG_ACC,
        ASL_FORM_ACC_SHORT,
        ASL_FORM_ACC_ABS,
        ASL_FORM_ACC_PTR,
        ASL_FORM_ACC_PTR_IDX
    } asl_form_e;

    localparam int ASL_DATA_W   = 8;
    localparam int ASL_LEN_W    = 2;
    localparam int ASL_CNT_W    = 8;
    localparam int ASL_NIBBLE_B = 4;

    localparam logic [1:0] ASL_LEN_ONE   = 2'h1;
    localparam logic [1:0] ASL_LEN_TWO   = 2'h2;
    localparam logic [1:0] ASL_LEN_THREE = 2'h3;

    localparam logic [7:0] ASL_CLK_4 = 8'h04;
    localparam logic [7:0] ASL_CLK_5 = 8'h05;
    localparam logic [7:0] ASL_CLK_6 = 8'h06;
    localparam logic [7:0] ASL_CLK_8 = 8'h08;
    localparam logic [7:0] ASL_CLK_9 = 8'h09;

    localparam logic [7:0] ASL_ZERO_BYTE = 8'h00;
endpackage : asl_pkg

//--- rtl/asl_cost.sv
// Instruction length and base cycle cost lookup for each operand form.
`timescale 1ns/1ps
`default_nettype none
module asl_cost
    import asl_pkg::*;
(
    input  wire asl_form_e  form_in,      // Operand form of the instruction
    input  wire logic       internal_in,  // Operand in internal high-speed RAM or no data access
    output logic [1:0]      len_out,      // Instruction length in bytes
    output logic [7:0]      base_out,     // Base clocks before read waits
    output logic            waits_out     // Read waits add to this form
);
    always_comb begin
        len_out   = ASL_LEN_TWO;
        base_out  = ASL_CLK_4;
        waits_out = 1'b0;
        unique case (form_in)
            ASL_FORM_ACC_IMM: begin
                len_out  = ASL_LEN_TWO;
                base_out = ASL_CLK_4;
            end
            ASL_FORM_SHORT_IMM: begin
                len_out  = ASL_LEN_THREE;
                base_out = internal_in ? ASL_CLK_6 : ASL_CLK_8;
            end
            ASL_FORM_ACC_REG, ASL_FORM_REG_ACC: begin
                len_out  = ASL_LEN_TWO;
                base_out = ASL_CLK_4;
            end
            ASL_FORM_ACC_SHORT: begin
                len_out  = ASL_LEN_TWO;
                base_out = internal_in ? ASL_CLK_4 : ASL_CLK_5;
            end
            ASL_FORM_ACC_ABS: begin
                len_out   = ASL_LEN_THREE;
                base_out  = internal_in ? ASL_CLK_8 : ASL_CLK_9;
                waits_out = !internal_in;
            end
            ASL_FORM_ACC_PTR: begin
                len_out   = ASL_LEN_ONE;
                base_out  = internal_in ? ASL_CLK_4 : ASL_CLK_5;
                waits_out = !internal_in;
            end
            ASL_FORM_ACC_PTR_IDX: begin
                len_out   = ASL_LEN_TWO;
                base_out  = internal_in ? ASL_CLK_8 : ASL_CLK_9;
                waits_out = !internal_in;
            end
        endcase
    end
endmodule : asl_cost
`default_nettype wire

//--- rtl/asl_datapath.sv
// Subtract, logic and compare datapath with flag update and per-form cycle timing.
`timescale 1ns/1ps
`default_nettype none
module asl_datapath
    import asl_pkg::*;
(
    input  wire logic             mclk_in,        // CPU clock, one instruction clock per period
    input  wire logic             rst_in,         // Asynchronous reset, active high
    input  wire logic             start_in,       // One-cycle pulse: begin an instruction
    input  wire asl_op_e          op_in,          // Operation to perform
    input  wire asl_form_e        form_in,        // Operand form
    input  wire logic             internal_in,    // Operand in internal high-speed RAM or no data access
    input  wire logic [7:0]       dest_in,        // Destination operand byte
    input  wire logic [7:0]       src_in,         // Source operand byte
    input  wire logic             read_wait_in,   // Expansion-area read wait, one clock per high cycle on forms that take waits
    output logic                  busy_out,       // Instruction in progress
    output logic                  done_out,       // One-cycle pulse at the last instruction clock
    output logic [7:0]            result_out,     // Result byte, valid with done_out
    output logic                  write_acc_out,  // Write result to the accumulator
    output logic                  write_reg_out,  // Write result to the general register
    output logic                  write_mem_out,  // Write result to the short direct location
    output logic                  zero_flag_out,  // Result-null flag
    output logic                  nibble_carry_flag_out, // Nibble-carry flag
    output logic                  carry_flag_out, // Carry flag
    output logic [1:0]            len_out,        // Instruction length in bytes
    output logic [7:0]            clocks_out      // Clocks the instruction took, valid with done_out
);
    typedef enum logic [1:0] {ASL_IDLE, ASL_RUN} asl_state_e;

    asl_state_e  state;
    asl_op_e     op;
    asl_form_e   form;
    logic [7:0]  dest;
    logic [7:0]  src;
    logic [7:0]  remain;
    logic [7:0]  elapsed;
    logic        waits_ok;
    logic [1:0]  cost_len;
    logic [7:0]  cost_base;
    logic        cost_waits;
    logic [8:0]  diff;
    logic [4:0]  low_diff;
    logic [7:0]  next_result;
    logic        next_borrow;
    logic        next_half;
    logic        is_sub;
    logic        last_clk;

    asl_cost u_cost (
        .form_in     (form_in),
        .internal_in (internal_in),
        .len_out     (cost_len),
        .base_out    (cost_base),
        .waits_out   (cost_waits)
    );

    // Borrow in only for the with-borrow operation; plain minus and compare ignore the carry.
    always_comb begin
        logic bin;
        bin = (op == ASL_OP_MINUS_WITH_BORROW) ? carry_flag_out : 1'b0;
        diff     = {1'b0, dest} - {1'b0, src} - {8'h00, bin};
        low_diff = {1'b0, dest[3:0]} - {1'b0, src[3:0]} - {4'h0, bin};
        is_sub   = (op == ASL_OP_MINUS) || (op == ASL_OP_MINUS_WITH_BORROW) || (op == ASL_OP_COMPARE);
        next_borrow = diff[ASL_DATA_W];
        next_half   = low_diff[ASL_NIBBLE_B];
        unique case (op)
            ASL_OP_AND: next_result = dest & src;
            ASL_OP_OR:  next_result = dest | src;
            ASL_OP_XOR: next_result = dest ^ src;
            default:    next_result = diff[7:0];
        endcase
    end

    // The last clock is reached only when the base count is spent and no read wait stands on a form that takes waits.
    assign last_clk = (state == ASL_RUN) && (remain == 8'h01) && !(waits_ok && read_wait_in);

    // Each period of mclk_in is one instruction clock; timing assumes fetch from internal ROM.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state    <= ASL_IDLE;
            remain   <= 8'h00;
            elapsed  <= 8'h00;
            waits_ok <= 1'b0;
        end else begin
            unique case (state)
                ASL_IDLE: begin
                    if (start_in) begin
                        state    <= ASL_RUN;
                        remain   <= cost_base - 8'h01;
                        elapsed  <= 8'h01;
                        waits_ok <= cost_waits;
                    end
                end
                ASL_RUN: begin
                    elapsed <= elapsed + 8'h01;
                    if (waits_ok && read_wait_in) begin
                        remain <= remain;
                    end else if (remain == 8'h01) begin
                        state <= ASL_IDLE;
                    end else begin
                        remain <= remain - 8'h01;
                    end
                end
                default: state <= ASL_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            op   <= ASL_OP_MINUS;
            form <= ASL_FORM_ACC_IMM;
            dest <= ASL_ZERO_BYTE;
            src  <= ASL_ZERO_BYTE;
        end else if (state == ASL_IDLE && start_in) begin
            op   <= op_in;
            form <= form_in;
            dest <= dest_in;
            src  <= src_in;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_out <= 1'b0;
            len_out  <= ASL_LEN_TWO;
        end else begin
            if (state == ASL_IDLE && start_in) begin
                busy_out <= 1'b1;
                len_out  <= cost_len;
            end else if (last_clk) begin
                busy_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            done_out      <= 1'b0;
            result_out    <= ASL_ZERO_BYTE;
            write_acc_out <= 1'b0;
            write_reg_out <= 1'b0;
            write_mem_out <= 1'b0;
            clocks_out    <= 8'h00;
        end else begin
            done_out      <= last_clk;
            write_acc_out <= 1'b0;
            write_reg_out <= 1'b0;
            write_mem_out <= 1'b0;
            if (last_clk) begin
                result_out <= next_result;
                clocks_out <= elapsed + 8'h01;
                if (op != ASL_OP_COMPARE) begin
                    write_reg_out <= (form == ASL_FORM_REG_ACC);
                    write_mem_out <= (form == ASL_FORM_SHORT_IMM);
                    write_acc_out <= (form != ASL_FORM_REG_ACC) && (form != ASL_FORM_SHORT_IMM);
                end
            end
        end
    end

    // Logic operations keep nibble-carry and carry so chained tests survive them.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            zero_flag_out         <= 1'b0;
            nibble_carry_flag_out <= 1'b0;
            carry_flag_out        <= 1'b0;
        end else if (last_clk) begin
            zero_flag_out <= (next_result == ASL_ZERO_BYTE);
            if (is_sub) begin
                nibble_carry_flag_out <= next_half;
                carry_flag_out        <= next_borrow;
            end
        end
    end

    // Helper: cycles since start, for timing checks.
    logic [7:0] age;
    logic [7:0] wait_seen;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            age       <= 8'h00;
            wait_seen <= 8'h00;
        end else if (state == ASL_IDLE) begin
            age       <= start_in ? 8'h01 : 8'h00;
            wait_seen <= 8'h00;
        end else begin
            age       <= age + 8'h01;
            wait_seen <= wait_seen + {7'h00, waits_ok && read_wait_in};
        end
    end

    property p_imm_four;
        @(posedge mclk_in) disable iff (rst_in)
        (state == ASL_IDLE && start_in && form_in == ASL_FORM_ACC_IMM) |-> ##4 done_out;
    endproperty
    a_imm_four: assert property (p_imm_four) else $error("immediate form did not end in 4 clocks");

    // Counting starts one edge after the start, since the previous done pulse may still stand at it.
    property p_short_imm;
        @(posedge mclk_in) disable iff (rst_in)
        (state == ASL_IDLE && start_in && form_in == ASL_FORM_SHORT_IMM && !internal_in)
            |=> !done_out [*7] ##1 done_out;
    endproperty
    a_short_imm: assert property (p_short_imm) else $error("short immediate external form not 8 clocks");

    property p_idx_internal;
        @(posedge mclk_in) disable iff (rst_in)
        (state == ASL_IDLE && start_in && form_in == ASL_FORM_ACC_PTR_IDX && internal_in)
            |=> !done_out [*7] ##1 done_out;
    endproperty
    a_idx_internal: assert property (p_idx_internal) else $error("indexed internal form not 8 clocks");

    property p_len_ptr;
        @(posedge mclk_in) disable iff (rst_in)
        (state == ASL_IDLE && start_in && form_in == ASL_FORM_ACC_PTR) |=> (len_out == ASL_LEN_ONE);
    endproperty
    a_len_ptr: assert property (p_len_ptr) else $error("pointer form length not 1");

    property p_short_len;
        @(posedge mclk_in) disable iff (rst_in)
        (state == ASL_IDLE && start_in && form_in == ASL_FORM_ACC_SHORT) |=> (len_out == ASL_LEN_TWO);
    endproperty
    a_short_len: assert property (p_short_len) else $error("short direct form length not 2");

    property p_abs_len;
        @(posedge mclk_in) disable iff (rst_in)
        (state == ASL_IDLE && start_in && form_in == ASL_FORM_ACC_ABS) |=> (len_out == ASL_LEN_THREE);
    endproperty
    a_abs_len: assert property (p_abs_len) else $error("absolute form length not 3");

    property p_clock_sum;
        @(posedge mclk_in) disable iff (rst_in)
        last_clk |=> (clocks_out == $past(age) + 8'h01 && clocks_out >= $past(wait_seen) + ASL_CLK_4);
    endproperty
    a_clock_sum: assert property (p_clock_sum) else $error("reported clocks disagree with elapsed");

    property p_compare_nowrite;
        @(posedge mclk_in) disable iff (rst_in)
        (last_clk && op == ASL_OP_COMPARE) |=> !(write_acc_out || write_reg_out || write_mem_out);
    endproperty
    a_compare_nowrite: assert property (p_compare_nowrite) else $error("compare wrote a result");

    property p_reg_write;
        @(posedge mclk_in) disable iff (rst_in)
        (last_clk && op != ASL_OP_COMPARE && form == ASL_FORM_REG_ACC)
            |=> (write_reg_out && !write_acc_out && !write_mem_out);
    endproperty
    a_reg_write: assert property (p_reg_write) else $error("reverse register form wrote elsewhere");

    property p_logic_keeps;
        @(posedge mclk_in) disable iff (rst_in)
        (last_clk && !is_sub) |=> $stable(carry_flag_out) && $stable(nibble_carry_flag_out);
    endproperty
    a_logic_keeps: assert property (p_logic_keeps) else $error("logic op changed carry flags");

    property p_or_result;
        @(posedge mclk_in) disable iff (rst_in)
        (last_clk && op == ASL_OP_OR) |=> (result_out == ($past(dest) | $past(src)));
    endproperty
    a_or_result: assert property (p_or_result) else $error("disjunction result wrong");

    property p_xor_result;
        @(posedge mclk_in) disable iff (rst_in)
        (last_clk && op == ASL_OP_XOR) |=> (result_out == ($past(dest) ^ $past(src)));
    endproperty
    a_xor_result: assert property (p_xor_result) else $error("exclusive disjunction result wrong");

    property p_zero_flag;
        @(posedge mclk_in) disable iff (rst_in)
        done_out |-> (zero_flag_out == (result_out == ASL_ZERO_BYTE));
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag does not match result");

    property p_nibble;
        @(posedge mclk_in) disable iff (rst_in)
        (last_clk && op == ASL_OP_MINUS) |=> (nibble_carry_flag_out == ($past(dest[3:0]) < $past(src[3:0])));
    endproperty
    a_nibble: assert property (p_nibble) else $error("nibble borrow wrong after minus");

    property p_borrow;
        @(posedge mclk_in) disable iff (rst_in)
        (last_clk && op == ASL_OP_MINUS) |=> (carry_flag_out == ($past(dest) < $past(src)));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow flag wrong after minus");

    property p_borrow_chain;
        @(posedge mclk_in) disable iff (rst_in)
        (last_clk && op == ASL_OP_MINUS_WITH_BORROW)
            |=> (carry_flag_out == ({1'b0, $past(dest)} < ({1'b0, $past(src)} + {8'h00, $past(carry_flag_out)})));
    endproperty
    a_borrow_chain: assert property (p_borrow_chain) else $error("borrow flag wrong after chained minus");
endmodule : asl_datapath
`default_nettype wire

//--- tb/asl_mem_model.sv
// Operand memory model that raises the read-wait line for a chosen number of cycles per instruction.
`timescale 1ns/1ps
`default_nettype none
module asl_mem_model (
    input  wire logic       mclk_in,       // CPU clock
    input  wire logic       rst_in,        // Asynchronous reset, active high
    input  wire logic       start_in,      // Instruction start request
    input  wire logic       busy_in,       // Datapath busy
    input  wire logic [3:0] waits_in,      // Waits to insert for the next instruction
    output logic            read_wait_out  // Expansion-area read wait
);
    logic [3:0] remaining;

    // Loading only on a taken start keeps a refused start from stretching the current read.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            remaining <= 4'h0;
        end else if (start_in && !busy_in) begin
            remaining <= waits_in;
        end else if (remaining != 4'h0) begin
            remaining <= remaining - 4'h1;
        end
    end

    assign read_wait_out = (remaining != 4'h0);
endmodule : asl_mem_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the subtract, logic and compare datapath.
`timescale 1ns/1ps
`default_nettype none
module tb
    import asl_pkg::*;
;
    logic       mclk_in     = 1'b0;
    logic       rst_in      = 1'b1;
    logic       start_in    = 1'b0;
    asl_op_e    op_in       = ASL_OP_MINUS;
    asl_form_e  form_in     = ASL_FORM_ACC_IMM;
    logic       internal_in = 1'b1;
    logic [7:0] dest_in     = 8'h00;
    logic [7:0] src_in      = 8'h00;
    logic [3:0] waits       = 4'h0;
    logic       read_wait_in;
    logic       busy_out;
    logic       done_out;
    logic [7:0] result_out;
    logic [2:0] writes;
    logic [2:0] flags;
    logic [1:0] len_out;
    logic [7:0] clocks_out;
    int         failures    = 0;
    int         comparisons = 0;
    logic [2:0] exp_flags   = 3'h0;

    always #25 mclk_in = ~mclk_in;

    asl_datapath dut (.mclk_in(mclk_in), .rst_in(rst_in), .start_in(start_in), .op_in(op_in),
        .form_in(form_in), .internal_in(internal_in), .dest_in(dest_in), .src_in(src_in),
        .read_wait_in(read_wait_in), .busy_out(busy_out), .done_out(done_out), .result_out(result_out),
        .write_acc_out(writes[2]), .write_reg_out(writes[1]), .write_mem_out(writes[0]),
        .zero_flag_out(flags[2]), .nibble_carry_flag_out(flags[1]), .carry_flag_out(flags[0]),
        .len_out(len_out), .clocks_out(clocks_out));

    asl_mem_model mem (.mclk_in(mclk_in), .rst_in(rst_in), .start_in(start_in), .busy_in(busy_out),
        .waits_in(waits), .read_wait_out(read_wait_in));

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte

    task automatic check_bits(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bits

    task automatic stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    task automatic do_reset();
        rst_in = 1'b1;
        start_in = 1'b0;
        repeat (5) @(negedge mclk_in);
        check_bits({busy_out, done_out, 1'b0}, 3'h0);
        check_bits(writes | flags, 3'h0);
        check_byte(result_out | clocks_out, 8'h00);
        check_byte({6'h00, len_out}, 8'h02);
        rst_in = 1'b0;
        exp_flags = 3'h0;
    endtask : do_reset

    // Entered at a falling edge; returns in the done cycle so the next call starts back to back.
    task automatic run(input asl_op_e op, input asl_form_e form, input logic intl, input logic [7:0] d,
                       input logic [7:0] s, input logic [3:0] n, input logic refuse);
        int         cin;
        int         k;
        logic [9:0] cost;
        logic [7:0] er;
        logic [2:0] ew;
        cin = (op == ASL_OP_MINUS_WITH_BORROW) ? int'(exp_flags[0]) : 0;
        case (op)
            ASL_OP_AND: er = d & s;
            ASL_OP_OR:  er = d | s;
            ASL_OP_XOR: er = d ^ s;
            default: begin
                er = 8'(int'(d) - int'(s) - cin);
                exp_flags[1] = (int'(d[3:0]) < int'(s[3:0]) + cin);
                exp_flags[0] = (int'(d) < int'(s) + cin);
            end
        endcase
        exp_flags[2] = (er == 8'h00);
        ew = (op == ASL_OP_COMPARE) ? 3'h0 : (form == ASL_FORM_REG_ACC) ? 3'h2
           : (form == ASL_FORM_SHORT_IMM) ? 3'h1 : 3'h4;
        case (form)
            ASL_FORM_ACC_IMM:     cost = {2'h2, 8'h04};
            ASL_FORM_SHORT_IMM:   cost = {2'h3, intl ? 8'h06 : 8'h08};
            ASL_FORM_ACC_SHORT:   cost = {2'h2, intl ? 8'h04 : 8'h05};
            ASL_FORM_ACC_ABS:     cost = {2'h3, intl ? 8'h08 : 8'(9 + n)};
            ASL_FORM_ACC_PTR:     cost = {2'h1, intl ? 8'h04 : 8'(5 + n)};
            ASL_FORM_ACC_PTR_IDX: cost = {2'h2, intl ? 8'h08 : 8'(9 + n)};
            default:              cost = {2'h2, 8'h04};
        endcase
        op_in = op;
        form_in = form;
        internal_in = intl;
        src_in = s;
        waits = n;
        start_in = 1'b1;
        k = 0;
        while (k == 0 || (done_out !== 1'b1 && k < 40)) begin
            dest_in = (refuse && k == 2) ? ~d : d;
            @(negedge mclk_in);
            k++;
            if (k <= 3) begin
                start_in = refuse && (k == 2);
            end
            if (k == 1) begin
                check_bits({busy_out, done_out, 1'b0}, 3'h4);
                check_byte({6'h00, len_out}, {6'h00, cost[9:8]});
            end
        end
        check_byte(8'(k), cost[7:0]);
        check_byte(clocks_out, cost[7:0]);
        if (op != ASL_OP_COMPARE) begin
            check_byte(result_out, er);
        end
        check_bits(flags, exp_flags);
        check_bits(writes, ew);
        check_bits({busy_out, 2'h0}, 3'h0);
    endtask : run

    initial begin
        void'($urandom(32'h467d));
        do_reset();
        for (int o = 0; o < 6; o++) begin
            for (int f = 0; f < 16; f++) begin
                run(asl_op_e'(o), asl_form_e'(f[2:0]), f[3], 8'($urandom), 8'($urandom),
                    4'($urandom_range(0, 3)), f[0]);
            end
        end
        run(ASL_OP_MINUS, ASL_FORM_ACC_IMM, 1'b1, 8'h05, 8'h07, 4'h0, 1'b0);
        run(ASL_OP_MINUS_WITH_BORROW, ASL_FORM_ACC_REG, 1'b1, 8'h10, 8'h0F, 4'h0, 1'b0);
        repeat (300) begin
            run(asl_op_e'($urandom_range(0, 5)), asl_form_e'($urandom_range(0, 7)), 1'($urandom),
                8'($urandom), 8'($urandom), 4'($urandom_range(0, 3)), 1'($urandom));
        end
        // A reset in mid-instruction must clear the stored borrow as well.
        op_in = ASL_OP_MINUS;
        dest_in = 8'h00;
        src_in = 8'h01;
        start_in = 1'b1;
        @(negedge mclk_in);
        start_in = 1'b0;
        @(negedge mclk_in);
        do_reset();
        run(ASL_OP_MINUS_WITH_BORROW, ASL_FORM_ACC_PTR, 1'b0, 8'h00, 8'h00, 4'h2, 1'b0);
        stop_test();
    end

    initial begin
        #(20000 * 50);
        failures++;
        stop_test();
    end
endmodule : tb
`default_nettype wire
